// file: hdl/rdc_defs.svh
// offsets, field positions, limits, sector bounds and counts of the converter host interface
// assumes inclusion by bare name from every design file that needs it
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

`define RDC_FRAME_BITS 6'h20
`define RDC_BIT_COUNT_MAX 6'h3f
`define RDC_IDX_ANGLE_STATUS 8'h05
`define RDC_IDX_VELOCITY_STATUS 8'h06
`define RDC_CMD_INDEX_MSB 31
`define RDC_CMD_INDEX_LSB 24
`define RDC_RESULT_MAX_10BIT 12'h3ff
`define RDC_STRAP_COUNT 7
`define RDC_STRAP_SETTLE 2'h3
`define RDC_SECTOR_1 12'h2ab
`define RDC_SECTOR_2 12'h555
`define RDC_SECTOR_3 12'h800
`define RDC_SECTOR_4 12'haab
`define RDC_SECTOR_5 12'hd55

`endif

// file: hdl/rdc_pkg.sv
// types shared by the converter host interface files
// assumes nothing beyond a SystemVerilog compiler
package rdc_pkg;

	typedef struct packed {
		logic parity;
		logic [11:0] value;
	} rdc_result_t;

	typedef struct packed {
		logic [7:0] index;
		logic [6:0] padHigh;
		logic parity;
		logic [3:0] padLow;
		logic [11:0] data;
	} rdc_reply_t;

	typedef struct packed {
		logic accel;
		logic res12;
		logic clkSel;
		logic outKind;
		logic commut;
		logic faultClear;
		logic resetN;
	} rdc_straps_t;

	typedef enum logic {
		SPI_IDLE,
		SPI_SHIFT
	} rdc_spi_state_t;

endpackage

// file: hdl/rdc_spi_shifter.sv
// serial port slave shifter: oversamples clock, select and data pins on ref_clk
// assumes serial clock idles low and is well below a quarter of ref_clk
`timescale 1ns/10ps
`include "rdc_defs.svh"
module rdc_spi_shifter
	import rdc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// serial pins
	input wire logic sclkIn,
	input wire logic chipSelectN,
	input wire logic sdiIn,
	output logic sdoOut,
	output logic sdoOen,
	// word side
	input wire rdc_reply_t txWord,
	output logic frameDone,
	output logic [31:0] rxWord
);

	logic [2:0] sclkSync;
	logic [1:0] csnSync;
	logic [1:0] sdiSync;
	rdc_spi_state_t state;
	logic [5:0] bitCount;
	logic [31:0] rxShift;
	logic [31:0] txShift;

	// sync stage 0 is read only by stage 1
	wire sclkRise = sclkSync[1] & ~sclkSync[2];
	wire sclkFall = ~sclkSync[1] & sclkSync[2];
	wire csActive = ~csnSync[1];
	wire inFrame = (state == SPI_SHIFT);

	// a frame counts only with exactly 32 clocks
	assign frameDone = inFrame & ~csActive & (bitCount == `RDC_FRAME_BITS); // RULE2
	assign rxWord = rxShift;
	assign sdoOut = txShift[31]; // RULE2
	assign sdoOen = ~inFrame; // RULE1

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclkSync <= 3'h0;
			csnSync <= 2'h3;
			sdiSync <= 2'h0;
		end
		else
		begin
			sclkSync <= {sclkSync[1:0], sclkIn};
			csnSync <= {csnSync[0], chipSelectN};
			sdiSync <= {sdiSync[0], sdiIn};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= SPI_IDLE;
			bitCount <= 6'h00;
			rxShift <= 32'h0000_0000;
			txShift <= 32'h0000_0000;
		end
		else
		begin
			unique case (state)
				SPI_IDLE:
					if (csActive) // RULE3
					begin
						state <= SPI_SHIFT;
						bitCount <= 6'h00;
						txShift <= txWord;
					end
				SPI_SHIFT:
					if (!csActive)
						state <= SPI_IDLE;
					else
					begin
						if (sclkRise)
						begin
							rxShift <= {rxShift[30:0], sdiSync[1]}; // RULE2
							if (bitCount != `RDC_BIT_COUNT_MAX)
								bitCount <= bitCount + 6'h01;
						end
						if (sclkFall)
							txShift <= {txShift[30:0], 1'b0};
					end
			endcase
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_frame_exact_bits: assert property (frameDone |-> bitCount == 6'h20) // RULE2
		else $error("frame accepted with wrong bit count");
	a_idle_ignores_clock: assert property (!inFrame |=> $stable(rxShift)) // RULE3
		else $error("receive shifter moved while deselected");
	a_sdo_released_idle: assert property (!csActive |=> sdoOen) // RULE1
		else $error("data pin driven outside a frame");
	a_msb_first_shift: assert property (inFrame && csActive && sclkRise
		|=> rxShift[0] == $past(sdiSync[1]) && rxShift[31:1] == $past(rxShift[30:0])) // RULE2
		else $error("receive bit not shifted in at the low end");

endmodule // rdc_spi_shifter

// file: hdl/rdc_host_interface.sv
// host side digital interface of a resolver converter: serial polling of
// angle and velocity, strap decoding, fault latch, parallel and encoder outputs
// assumes results and diagnostics come from tracking logic on ref_clk
//
// What this block does
// RULE1: device is serial slave only; never drives serial clock or select.
// RULE2: frames are exactly 32 bits, most significant bit first both ways.
// RULE3: select is active low; clock and data ignored while it is high.
// RULE4: angle and velocity kept in registers the host may poll anytime.
// RULE5: resolution strap low gives 10-bit results 0..1023 on low ten lines.
// RULE6: resolution strap high gives 12-bit results 0..4095 on all twelve lines.
// RULE7: reserved resolution strap is held low outside; only the first strap counts.
// RULE8: accelerated-mode pin enables the tracking loop acceleration stage.
// RULE9: parity bit for angle in one status register, velocity in another.
// RULE10: fault output toward host, separate fault-clear input from host.
// RULE11: quadrature phases plus index emulated, or commutation signals instead.
// RULE12: host reset input resets the device.
// RULE13: clock strap low selects internal oscillator, high external crystal.
// RULE14: output-mode strap high gives parallel data, low encoder signals.
// RULE15: velocity is two's complement; 10-bit mode sign-fills top two lines.
// RULE16: parity is even over active result bits, updated with its word.
`timescale 1ns/10ps
`include "rdc_defs.svh"
module rdc_host_interface
	import rdc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// serial port pins
	input wire logic sclkIn,
	input wire logic chipSelectN,
	input wire logic sdiIn,
	output logic sdoOut,
	output logic sdoOen,
	// strap and host control pins
	input wire logic accelEnablePin,
	input wire logic resolutionSelectPin,
	input wire logic clockSourceSelect,
	input wire logic outputKindSelect,
	input wire logic commutationSelect,
	input wire logic faultClearIn,
	input wire logic resetNIn,
	output logic faultOut,
	// tracking loop side
	input wire logic [11:0] angleIn,
	input wire logic [11:0] velocityIn,
	input wire logic resultValid,
	input wire logic diagFault,
	output logic accelEnable,
	output logic externalOscSelect,
	output logic softReset,
	// shared parallel and encoder lines
	output logic [11:0] parallelResultBus,
	output logic quadPhaseA,
	output logic quadPhaseB,
	output logic quadIndex
);

	logic [`RDC_STRAP_COUNT-1:0] strapBits;
	rdc_straps_t strap;
	logic [1:0] settleCount;
	logic clkTaken;
	rdc_result_t angleReg;
	rdc_result_t velocityReg;
	rdc_reply_t txWord;
	logic frameDone;
	logic [31:0] rxWord;

	wire [`RDC_STRAP_COUNT-1:0] pinRaw = {accelEnablePin, resolutionSelectPin, clockSourceSelect,
		outputKindSelect, commutationSelect, faultClearIn, resetNIn};

	// every pin passes two flops before use
	for (genvar i = 0; i < `RDC_STRAP_COUNT; i++)
	begin : g_pin_sync
		logic meta;
		logic held;
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				meta <= 1'b0;
				held <= 1'b0;
			end
			else
			begin
				meta <= pinRaw[i];
				held <= meta;
			end
		end
		assign strapBits[i] = held;
	end

	assign strap = rdc_straps_t'(strapBits);
	assign softReset = ~strap.resetN; // RULE12
	assign accelEnable = strap.accel; // RULE8

	// the second resolution strap is never read; the first alone decides
	wire res12 = strap.res12; // RULE7
	wire [11:0] angleAct = res12 ? angleIn : {2'b00, angleIn[11:2]}; // RULE5 RULE6
	wire [11:0] velocityAct = res12 ? velocityIn
		: {{2{velocityIn[11]}}, velocityIn[11:2]}; // RULE15
	// sign fill adds two equal bits, so the full xor equals the active xor
	wire angleParity = ^angleAct; // RULE16
	wire velocityParity = ^velocityAct; // RULE16

	wire [7:0] cmdIndex = rxWord[`RDC_CMD_INDEX_MSB:`RDC_CMD_INDEX_LSB];
	wire selAngle = (cmdIndex == `RDC_IDX_ANGLE_STATUS);
	wire selVelocity = (cmdIndex == `RDC_IDX_VELOCITY_STATUS);
	wire rdc_result_t selResult = selAngle ? angleReg
		: (selVelocity ? velocityReg : 13'h0000);
	wire rdc_reply_t nextReply = {cmdIndex, 7'h00, selResult.parity, 4'h0, selResult.value};

	// encoder emulation from the held angle
	wire [11:0] fullAngle = res12 ? angleReg.value : {angleReg.value[9:0], 2'b00};
	wire encA = angleReg.value[1];
	wire encB = angleReg.value[1] ^ angleReg.value[0];
	wire encZ = (angleReg.value == 12'h000);
	wire comU = (fullAngle < `RDC_SECTOR_3);
	wire comV = (fullAngle >= `RDC_SECTOR_2) && (fullAngle < `RDC_SECTOR_5);
	wire comW = (fullAngle >= `RDC_SECTOR_4) || (fullAngle < `RDC_SECTOR_1);
	wire next_phaseA = strap.commut ? comU : encA; // RULE11
	wire next_phaseB = strap.commut ? comV : encB; // RULE11
	wire next_index = strap.commut ? comW : encZ; // RULE11
	wire [11:0] next_parallel = strap.outKind ? angleReg.value
		: {9'h000, next_index, next_phaseB, next_phaseA}; // RULE14

	rdc_spi_shifter u_shifter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.sclkIn(sclkIn),
		.chipSelectN(chipSelectN),
		.sdiIn(sdiIn),
		.sdoOut(sdoOut),
		.sdoOen(sdoOen),
		.txWord(txWord),
		.frameDone(frameDone),
		.rxWord(rxWord)
	);

	// clock strap is a level caught once the synchroniser has settled
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			settleCount <= 2'h0;
			clkTaken <= 1'b0;
			externalOscSelect <= 1'b0;
		end
		else if (settleCount != `RDC_STRAP_SETTLE)
			settleCount <= settleCount + 2'h1;
		else if (!clkTaken)
		begin
			clkTaken <= 1'b1;
			externalOscSelect <= strap.clkSel; // RULE13
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			angleReg <= 13'h0000;
			velocityReg <= 13'h0000;
		end
		else if (softReset)
		begin
			angleReg <= 13'h0000; // RULE12
			velocityReg <= 13'h0000;
		end
		else if (resultValid)
		begin
			angleReg <= {angleParity, angleAct}; // RULE4 RULE9
			velocityReg <= {velocityParity, velocityAct}; // RULE4 RULE9
		end
	end

	// answer goes out in the frame after the command
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			txWord <= 32'h0000_0000;
		else if (frameDone)
			txWord <= nextReply; // RULE4
	end

	// a new fault wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			faultOut <= 1'b0;
		else if (softReset)
			faultOut <= 1'b0;
		else if (diagFault)
			faultOut <= 1'b1; // RULE10
		else if (strap.faultClear)
			faultOut <= 1'b0; // RULE10
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			parallelResultBus <= 12'h000;
			quadPhaseA <= 1'b0;
			quadPhaseB <= 1'b0;
			quadIndex <= 1'b0;
		end
		else
		begin
			parallelResultBus <= next_parallel;
			quadPhaseA <= next_phaseA;
			quadPhaseB <= next_phaseB;
			quadIndex <= next_index;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_angle_range_ten: assert property (resultValid && !softReset && !res12
		|=> angleReg.value <= 12'h3ff) // RULE5
		else $error("10-bit angle out of range");
	a_angle_full_twelve: assert property (resultValid && !softReset && res12
		|=> angleReg.value == $past(angleIn)) // RULE6
		else $error("12-bit angle not taken whole");
	a_velocity_sign_fill: assert property (resultValid && !softReset && !res12
		|=> velocityReg.value[11:10] == {2{velocityReg.value[9]}}
		&& velocityReg.value[9:0] == $past(velocityIn[11:2])) // RULE15
		else $error("velocity sign fill wrong");
	a_parity_even_words: assert property (^angleReg == 1'b0 && ^velocityReg == 1'b0) // RULE16
		else $error("stored word parity not even");
	a_status_reply_angle: assert property (frameDone && selAngle
		|=> txWord.data == $past(angleReg.value) && txWord.parity == $past(angleReg.parity)) // RULE9
		else $error("angle status reply mismatch");
	a_status_reply_velocity: assert property (frameDone && selVelocity
		|=> txWord.data == $past(velocityReg.value) && txWord.index == 8'h06) // RULE4
		else $error("velocity status reply mismatch");
	a_fault_set_wins: assert property (diagFault && !softReset |=> faultOut) // RULE10
		else $error("fault event lost");
	a_fault_clear_done: assert property (strap.faultClear && !diagFault && !softReset
		|=> !faultOut) // RULE10
		else $error("fault clear ignored");
	a_host_reset_clears: assert property (softReset |=> !faultOut && angleReg == 13'h0000) // RULE12
		else $error("host reset did not clear state");
	a_parallel_kind: assert property (strap.outKind |=> parallelResultBus == $past(angleReg.value)) // RULE14
		else $error("parallel lines not carrying angle");
	a_encoder_kind: assert property (!strap.outKind |=> parallelResultBus[11:3] == 9'h000
		&& parallelResultBus[0] == quadPhaseA) // RULE11
		else $error("encoder lines not carrying phases");

	c_poll_angle: cover property (frameDone && selAngle);
	c_poll_velocity: cover property (frameDone && selVelocity);
	c_fault_raise: cover property (!faultOut ##1 faultOut);
	c_ten_bit_result: cover property (resultValid && !res12 && velocityIn[11]);

endmodule // rdc_host_interface

// file: testbench/rdc_host_model.sv
// host serial port master model driving the converter's four-wire port
// assumes the bench calls its tasks just after a falling edge of ref_clk
`timescale 1ns/10ps
module rdc_host_model
(
	// serial pins toward the converter
	output logic sclk,
	output logic chipSelectN,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdoOen
);
	real halfNs = 62.5;
	logic lastSdo = 1'b0;
	initial
	begin
		sclk = 1'b0;
		chipSelectN = 1'b1;
		sdi = 1'b0;
	end
	// master alone owns clock and select
	task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
		rx = 32'h0;
		#1.25;
		chipSelectN = 1'b0;
		#(2.0 * halfNs);
		for (int i = 31; i > 31 - nBits; i--)
		begin
			sdi = tx[i];
			#(halfNs);
			sclk = 1'b1;
			// undriven line shows no stale bit
			lastSdo = sdoOen ? ~lastSdo : sdo;
			rx = {rx[30:0], lastSdo};
			#(halfNs);
			sclk = 1'b0;
		end
		#(halfNs);
		chipSelectN = 1'b1;
		sdi = ~sdi;
		#(2.0 * halfNs);
	endtask
	// clock and data wiggle while deselected
	task automatic idleClocks();
		repeat (8)
		begin
			#(halfNs);
			sclk = ~sclk;
			sdi = ~sdi;
		end
	endtask
endmodule // rdc_host_model

// file: testbench/rdc_host_interface_tb.sv
// self-checking bench for the converter host interface
// assumes the host model stands on the serial pins, straps driven here
`timescale 1ns/10ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", w, e, g); end end
module rdc_host_interface_tb
	import rdc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	wire sclk, csn, sdi;
	logic sdoOut, sdoOen, faultOut, accelEn, extOsc, softReset, qa, qb, qz;
	logic [11:0] angle, velocity, bus;
	logic resValid, diagFault;
	logic [31:0] rx;
	rdc_straps_t straps;
	int errors = 0;
	int n_checks = 0;

	always #5 ref_clk = ~ref_clk;

	rdc_host_interface DUT (.ref_clk(ref_clk), .rstn(rstn), .sclkIn(sclk), .chipSelectN(csn),
		.sdiIn(sdi), .sdoOut(sdoOut), .sdoOen(sdoOen), .accelEnablePin(straps.accel),
		.resolutionSelectPin(straps.res12), .clockSourceSelect(straps.clkSel),
		.outputKindSelect(straps.outKind), .commutationSelect(straps.commut),
		.faultClearIn(straps.faultClear), .resetNIn(straps.resetN), .faultOut(faultOut),
		.angleIn(angle), .velocityIn(velocity), .resultValid(resValid),
		.diagFault(diagFault), .accelEnable(accelEn), .externalOscSelect(extOsc),
		.softReset(softReset), .parallelResultBus(bus), .quadPhaseA(qa), .quadPhaseB(qb),
		.quadIndex(qz));

	rdc_host_model host (.sclk(sclk), .chipSelectN(csn), .sdi(sdi), .sdo(sdoOut),
		.sdoOen(sdoOen));

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic load(input logic [11:0] a, input logic [11:0] v);
		angle = a;
		velocity = v;
		resValid = 1'b1;
		cyc(1);
		resValid = 1'b0;
		cyc(3);
	endtask

	// reply to a command arrives in the following frame
	task automatic poll(input logic [7:0] idx, input logic [11:0] d);
		rdc_reply_t r;
		r = '{index: idx, padHigh: 7'h0, parity: ^d, padLow: 4'h0, data: d};
		// each frame starts just after a falling edge, never on a sampling edge
		cyc(1);
		host.xfer({idx, 24'h0}, 32, rx);
		cyc(1);
		host.xfer(32'h0, 32, rx);
		`CHK("reply", r, rx)
		cyc(1);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic t_straps();
		`CHK("sdoOen idle", 1'b1, sdoOen)
		`CHK("extOsc", 1'b1, extOsc)
		`CHK("accel off", 1'b0, accelEn)
		straps.accel = 1'b1;
		cyc(3);
		`CHK("accel on", 1'b1, accelEn)
	endtask

	task automatic t_res12();
		load(12'habc, 12'h876);
		`CHK("bus12", 12'habc, bus)
		poll(8'h05, 12'habc);
		poll(8'h06, 12'h876);
		poll(8'h07, 12'h000);
	endtask

	// short frame must leave the pending reply untouched
	task automatic t_frame();
		host.xfer({8'h05, 24'h0}, 32, rx);
		cyc(1);
		host.idleClocks();
		`CHK("sdoOen deselected", 1'b1, sdoOen)
		cyc(1);
		host.xfer({8'h06, 24'h0}, 31, rx);
		cyc(1);
		host.xfer(32'h0, 32, rx);
		`CHK("after short", {8'h05, 7'h0, 1'b1, 4'h0, 12'habc}, rx)
		cyc(1);
	endtask

	task automatic t_res10();
		straps.res12 = 1'b0;
		host.halfNs = 187.5;
		cyc(3);
		load(12'hfff, 12'h800);
		`CHK("bus10", 12'h3ff, bus)
		poll(8'h05, 12'h3ff);
		poll(8'h06, 12'he00);
		host.halfNs = 62.5;
		straps.res12 = 1'b1;
	endtask

	task automatic t_encoder();
		straps.outKind = 1'b0;
		cyc(3);
		load(12'h003, 12'h0);
		`CHK("enc bus", 12'h001, bus)
		`CHK("enc abz", 3'b001, {qz, qb, qa})
		load(12'h000, 12'h0);
		`CHK("enc index", 3'b100, {qz, qb, qa})
		straps.commut = 1'b1;
		cyc(3);
		load(12'h000, 12'h0);
		`CHK("uvw zero", 3'b101, {qz, qb, qa})
		load(12'h800, 12'h0);
		`CHK("uvw half", 3'b010, {qz, qb, qa})
		straps.commut = 1'b0;
		straps.outKind = 1'b1;
	endtask

	task automatic t_fault();
		int k;
		diagFault = 1'b1;
		cyc(1);
		diagFault = 1'b0;
		`CHK("fault set", 1'b1, faultOut)
		cyc(2);
		`CHK("fault held", 1'b1, faultOut)
		straps.faultClear = 1'b1;
		for (k = 0; k < 8 && faultOut !== 1'b0; k++)
			cyc(1);
		`CHK("fault clear", 1'b0, faultOut)
		// event and clear in one cycle: the event wins
		diagFault = 1'b1;
		cyc(1);
		diagFault = 1'b0;
		`CHK("fault set wins", 1'b1, faultOut)
		cyc(1);
		`CHK("fault clear again", 1'b0, faultOut)
		straps.faultClear = 1'b0;
	endtask

	task automatic t_hostReset();
		load(12'h5a5, 12'h0);
		straps.resetN = 1'b0;
		cyc(4);
		`CHK("softReset", 1'b1, softReset)
		`CHK("bus cleared", 12'h000, bus)
		straps.resetN = 1'b1;
		cyc(4);
		`CHK("softReset off", 1'b0, softReset)
	endtask

	// clock strap is caught once after a reset release, later changes ignored
	task automatic t_clkStrap();
		straps.clkSel = 1'b0;
		cyc(3);
		rstn = 1'b0;
		cyc(5);
		rstn = 1'b1;
		cyc(8);
		`CHK("extOsc internal", 1'b0, extOsc)
		straps.clkSel = 1'b1;
		cyc(6);
		`CHK("extOsc latched", 1'b0, extOsc)
	endtask

	initial
	begin
		// reserved resolution strap has no port; it is held low
		straps = '0;
		straps.resetN = 1'b1;
		straps.res12 = 1'b1;
		straps.clkSel = 1'b1;
		straps.outKind = 1'b1;
		angle = 12'h0;
		velocity = 12'h0;
		resValid = 1'b0;
		diagFault = 1'b0;
		cyc(5);
		rstn = 1'b1;
		cyc(8);
		t_straps();
		t_res12();
		t_frame();
		t_res10();
		t_encoder();
		t_fault();
		t_hostReset();
		t_clkStrap();
		wrap_up();
	end

	// hang guard
	initial
	begin
		#800000;
		errors++;
		wrap_up();
	end
endmodule // rdc_host_interface_tb
